//--- rtl/ldm_link_delay_ptm_sync.sv
// Link delay measurement requester and responder plus PTM bus interval counters.
// Assumes all inputs synchronous to core_clk_i and packet strobes one cycle long.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module ldm_link_delay_ptm_sync #(
    parameter int RSP_TIMEOUT_NS = 10000,
    parameter int RSP_DELAY_LIMIT_NS = 20000,
    parameter int TP_DEFAULT_DELAY_TICKS = 400,
    parameter int TX_TS_DELAY_TICKS = 0,
    parameter int RX_TS_DELAY_TICKS = 0
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic bus_reset_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic req_trigger_i,
    input wire logic set_feature_ldm_i,
    input wire logic clear_feature_ldm_i,
    input wire logic ts_rsp_rx_i,
    input wire ldm_ptm_pkg::ts_rsp_in_s ts_rsp_in_i,
    output logic ts_req_tx_o,
    output logic ldm_enabled_o,
    output logic ldm_valid_o,
    output logic [31:0] link_delay_o,
    input wire logic resp_ldm_enabled_i,
    input wire logic ts_req_rx_i,
    input wire logic rsp_trigger_i,
    input wire logic [10:0] lcw_base_i,
    output logic ts_rsp_tx_o,
    output ldm_ptm_pkg::ts_rsp_out_s ts_rsp_out_o,
    input wire logic itp_rx_i,
    input wire ldm_ptm_pkg::itp_s itp_rx_data_i,
    input wire logic itp_tx_req_i,
    output logic itp_tx_stb_o,
    output ldm_ptm_pkg::itp_s itp_tx_data_o,
    output logic [12:0] ptm_delta_o,
    output logic [13:0] ptm_bic_o
);

    // ==========================================================
    // Derived counts
    // ==========================================================
    localparam int RSP_TIMEOUT_CLKS =
        (RSP_TIMEOUT_NS * 1000 + ldm_ptm_pkg::CLK_PERIOD_PS - 1) / ldm_ptm_pkg::CLK_PERIOD_PS;
    localparam int RSP_TIMEOUT_TICKS = RSP_TIMEOUT_NS * 1000 / ldm_ptm_pkg::TICK_PS;
    localparam int RSP_LIMIT_TICKS = RSP_DELAY_LIMIT_NS * 1000 / ldm_ptm_pkg::TICK_PS;
    localparam int TW = ldm_ptm_pkg::TW;

    if (RSP_TIMEOUT_NS < 1 || RSP_DELAY_LIMIT_NS < 1 || TP_DEFAULT_DELAY_TICKS < 0
        || TX_TS_DELAY_TICKS < 0 || RX_TS_DELAY_TICKS < 0) begin : g_bad_param
        $error("ldm_link_delay_ptm_sync: timing parameter out of range");
    end

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        ldm_ptm_pkg::req_state_e req;
        logic [1:0] init_cnt;
        logic ldm_enabled;
        logic ldm_valid;
        logic trig_pend;
        logic [TW-1:0] rsp_timer;
        logic [TW-1:0] t1;
        logic t1_ok;
        logic [TW-1:0] t4;
        logic [TW-1:0] link_delay;
        logic req_tx;
        ldm_ptm_pkg::rsp_state_e rsp;
        logic [TW-1:0] t2;
        logic rsp_tx;
        ldm_ptm_pkg::ts_rsp_out_s rsp_out;
        logic [TW-1:0] local_time;
        logic [12:0] delta_cnt;
        logic [13:0] bic;
        logic cnt_run;
        logic itp_tx_stb;
        ldm_ptm_pkg::itp_s itp_tx;
        logic [31:0] ctrl;
        logic [31:0] isoch;
        logic [31:0] rdata;
    } state_s;

    state_s st;
    state_s next_st;

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [4:0] crc5(input logic [10:0] data);
        logic [4:0] c;
        logic fb;
        c = ldm_ptm_pkg::CRC5_INIT;
        for (int i = 0; i < 11; i++) begin
            fb = c[4] ^ data[i];
            c = {c[3:0], 1'b0};
            if (fb) begin
                c = c ^ ldm_ptm_pkg::CRC5_POLY;
            end
        end
        return ~c;
    endfunction : crc5

    // Half round trip, then swap default TP time for the link's own
    function automatic logic [TW-1:0] calc_delay(input logic [TW-1:0] t1,
                                                 input logic [TW-1:0] t4,
                                                 input logic [TW-1:0] rd,
                                                 input logic gen2);
        logic [TW-1:0] half;
        logic [TW-1:0] tp;
        half = TW'($signed(t4 - t1 - rd) >>> 1);
        tp = gen2 ? TW'(ldm_ptm_pkg::GEN2_TP_TICKS)
                  : TW'(ldm_ptm_pkg::GEN1_TP_TICKS);
        return half + tp - TW'(TP_DEFAULT_DELAY_TICKS);
    endfunction : calc_delay

    function automatic logic [12:0] mod_interval(input logic signed [TW+1:0] v);
        logic signed [TW+1:0] r;
        r = v % (TW+2)'(ldm_ptm_pkg::BUS_INTERVAL_DELTAS);
        if (r < 0) begin
            r = r + (TW+2)'(ldm_ptm_pkg::BUS_INTERVAL_DELTAS);
        end
        return r[12:0];
    endfunction : mod_interval

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        logic trig;
        logic gen2;
        logic host;
        logic [TW-1:0] now;
        logic [TW-1:0] t4c;
        logic [TW-1:0] d32;
        logic signed [TW+1:0] dsum;
        logic [TW:0] lsum;
        logic [TW:0] quot;
        logic [10:0] lcw;
        logic rsp_seen;
        trig = 1'b0;
        gen2 = st.ctrl[ldm_ptm_pkg::CTRL_GEN2_BIT];
        host = st.ctrl[ldm_ptm_pkg::CTRL_HOST_BIT];
        now = st.local_time;
        t4c = now - TW'(RX_TS_DELAY_TICKS);
        d32 = '0;
        dsum = '0;
        lsum = '0;
        quot = '0;
        lcw = lcw_base_i;
        rsp_seen = 1'b0;
        next_st = st;
        next_st.req_tx = 1'b0;
        next_st.rsp_tx = 1'b0;
        next_st.itp_tx_stb = 1'b0;
        // Ticks of 100 ps keep both TP times exact
        next_st.local_time = now + TW'(ldm_ptm_pkg::TICKS_PER_CLK);

        // Requester
        trig = req_trigger_i | st.trig_pend;
        case (st.req)
            ldm_ptm_pkg::REQ_INIT_REQUEST: begin
                next_st.ldm_enabled = 1'b1;
                next_st.ldm_valid = 1'b0;
                if (trig) begin
                    next_st.req_tx = 1'b1;
                    next_st.t1 = now + TW'(TX_TS_DELAY_TICKS);
                    next_st.t1_ok = 1'b1;
                    next_st.trig_pend = 1'b0;
                    next_st.init_cnt = st.init_cnt + 2'h1;
                    next_st.rsp_timer = '0;
                    next_st.req = ldm_ptm_pkg::REQ_INIT_RESPONSE;
                end
            end
            ldm_ptm_pkg::REQ_TS_REQUEST: begin
                if (trig) begin
                    next_st.req_tx = 1'b1;
                    next_st.t1 = now + TW'(TX_TS_DELAY_TICKS);
                    next_st.t1_ok = 1'b1;
                    next_st.trig_pend = 1'b0;
                    next_st.rsp_timer = '0;
                    next_st.req = ldm_ptm_pkg::REQ_TS_RESPONSE;
                end
            end
            ldm_ptm_pkg::REQ_INIT_RESPONSE, ldm_ptm_pkg::REQ_TS_RESPONSE: begin
                next_st.rsp_timer = st.rsp_timer + TW'(1);
                if (ts_rsp_rx_i) begin
                    rsp_seen = 1'b1;
                    next_st.req = ldm_ptm_pkg::REQ_TS_REQUEST;
                    if (!ts_rsp_in_i.delayed) begin
                        next_st.t4 = t4c;
                        next_st.link_delay = calc_delay(st.t1, t4c,
                                                        ts_rsp_in_i.resp_delay, gen2);
                        next_st.ldm_valid = 1'b1;
                    end else begin
                        next_st.t1_ok = 1'b0;
                        next_st.trig_pend = 1'b1;
                    end
                end else if (st.rsp_timer >= TW'(RSP_TIMEOUT_CLKS)) begin
                    next_st.req = ldm_ptm_pkg::REQ_INIT_REQUEST;
                    if (st.req == ldm_ptm_pkg::REQ_TS_RESPONSE) begin
                        next_st.init_cnt = 2'h0;
                    end else if (st.init_cnt == ldm_ptm_pkg::INIT_TIMEOUT_LIMIT) begin
                        next_st.req = ldm_ptm_pkg::REQ_DISABLED;
                        next_st.ldm_enabled = 1'b0;
                        next_st.ldm_valid = 1'b0;
                    end else begin
                        next_st.init_cnt = st.init_cnt + 2'h1;
                    end
                end
            end
            ldm_ptm_pkg::REQ_DISABLED: begin
                next_st.ldm_enabled = 1'b0;
                next_st.ldm_valid = 1'b0;
                next_st.trig_pend = 1'b0;
            end
            default: begin
                next_st.req = ldm_ptm_pkg::REQ_INIT_REQUEST;
            end
        endcase

        if (clear_feature_ldm_i) begin
            next_st.req = ldm_ptm_pkg::REQ_DISABLED;
            next_st.ldm_enabled = 1'b0;
            next_st.ldm_valid = 1'b0;
            next_st.trig_pend = 1'b0;
            next_st.req_tx = 1'b0;
        end else if (set_feature_ldm_i) begin
            next_st.req = ldm_ptm_pkg::REQ_INIT_REQUEST;
            next_st.ldm_enabled = 1'b1;
            next_st.init_cnt = 2'h0;
            next_st.ldm_valid = 1'b0;
            next_st.trig_pend = 1'b0;
            next_st.req_tx = 1'b0;
        end

        // Responder
        if (!resp_ldm_enabled_i) begin
            next_st.rsp = ldm_ptm_pkg::RSP_DISABLED;
        end else begin
            case (st.rsp)
                ldm_ptm_pkg::RSP_DISABLED: begin
                    next_st.rsp = ldm_ptm_pkg::RSP_TS_REQUEST;
                end
                ldm_ptm_pkg::RSP_TS_REQUEST: begin
                    if (ts_req_rx_i) begin
                        next_st.t2 = now - TW'(RX_TS_DELAY_TICKS);
                        next_st.rsp = ldm_ptm_pkg::RSP_TS_RESPONSE;
                    end
                end
                ldm_ptm_pkg::RSP_TS_RESPONSE: begin
                    if (rsp_trigger_i) begin
                        d32 = now + TW'(TX_TS_DELAY_TICKS) - st.t2;
                        next_st.rsp = ldm_ptm_pkg::RSP_TS_REQUEST;
                        if (d32 < TW'(RSP_LIMIT_TICKS)) begin
                            lcw[ldm_ptm_pkg::LCW_DL_BIT] = d32 > TW'(RSP_TIMEOUT_TICKS);
                            next_st.rsp_tx = 1'b1;
                            next_st.rsp_out.resp_delay = d32;
                            next_st.rsp_out.lcw = {lcw, crc5(lcw)};
                        end
                        // Else nothing goes out: the request is dropped
                    end
                end
                default: begin
                    next_st.rsp = ldm_ptm_pkg::RSP_DISABLED;
                end
            endcase
        end

        // PTM counters, free running once loaded or in host mode
        if (st.cnt_run || host) begin
            if (st.delta_cnt == 13'(ldm_ptm_pkg::BUS_INTERVAL_DELTAS - 1)) begin
                next_st.delta_cnt = 13'h0000;
                next_st.bic = st.bic + 14'h0001;
            end else begin
                next_st.delta_cnt = st.delta_cnt + 13'h0001;
            end
        end
        if (host) begin
            if (itp_tx_req_i) begin
                next_st.itp_tx_stb = 1'b1;
                next_st.itp_tx.bic = st.bic;
                next_st.itp_tx.delta = st.delta_cnt;
                next_st.itp_tx.corr = 7'h00;
            end
        end else if (itp_rx_i
                     && itp_rx_data_i.delta < 13'(ldm_ptm_pkg::BUS_INTERVAL_DELTAS)) begin
            dsum = $signed({21'h000000, itp_rx_data_i.delta})
                 + $signed({2'h0, st.link_delay})
                 + $signed({2'h0, st.isoch})
                 - $signed({27'h0000000, itp_rx_data_i.corr});
            next_st.delta_cnt = mod_interval(dsum);
            lsum = {1'b0, st.link_delay} + {20'h00000, itp_rx_data_i.delta};
            quot = lsum / (TW+1)'(ldm_ptm_pkg::BUS_INTERVAL_DELTAS);
            next_st.bic = itp_rx_data_i.bic + quot[13:0];
            next_st.cnt_run = 1'b1;
        end

        // Register port
        if (reg_wr_i) begin
            case (reg_addr_i)
                ldm_ptm_pkg::CTRL_OFS: next_st.ctrl = {30'h00000000, reg_wdata_i[1:0]};
                ldm_ptm_pkg::ISOCH_OFS: next_st.isoch = reg_wdata_i;
                default: begin
                end
            endcase
        end
        next_st.rdata = 32'h00000000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                ldm_ptm_pkg::CTRL_OFS: next_st.rdata = st.ctrl;
                ldm_ptm_pkg::ISOCH_OFS: next_st.rdata = st.isoch;
                ldm_ptm_pkg::STATUS_OFS: begin
                    next_st.rdata[ldm_ptm_pkg::STATUS_EN_BIT] = st.ldm_enabled;
                    next_st.rdata[ldm_ptm_pkg::STATUS_VALID_BIT] = st.ldm_valid;
                    next_st.rdata[ldm_ptm_pkg::STATUS_REQ_LSB +: 3] = st.req;
                    next_st.rdata[ldm_ptm_pkg::STATUS_RSP_LSB +: 2] = st.rsp;
                end
                ldm_ptm_pkg::LINK_DELAY_OFS: next_st.rdata = st.link_delay;
                default: next_st.rdata = 32'h00000000;
            endcase
        end

        // Hot or warm reset restarts both machines
        if (bus_reset_i) begin
            next_st.req = ldm_ptm_pkg::REQ_INIT_REQUEST;
            next_st.init_cnt = 2'h0;
            next_st.ldm_valid = 1'b0;
            next_st.trig_pend = 1'b0;
            next_st.req_tx = 1'b0;
            next_st.rsp = ldm_ptm_pkg::RSP_DISABLED;
            next_st.rsp_tx = 1'b0;
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            st <= '0;
            st.ctrl <= ldm_ptm_pkg::CTRL_RESET;
            st.isoch <= ldm_ptm_pkg::ISOCH_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_o = st.rdata;
    assign ts_req_tx_o = st.req_tx;
    assign ldm_enabled_o = st.ldm_enabled;
    assign ldm_valid_o = st.ldm_valid;
    assign link_delay_o = st.link_delay;
    assign ts_rsp_tx_o = st.rsp_tx;
    assign ts_rsp_out_o = st.rsp_out;
    assign itp_tx_stb_o = st.itp_tx_stb;
    assign itp_tx_data_o = st.itp_tx;
    assign ptm_delta_o = st.delta_cnt;
    assign ptm_bic_o = st.bic;

endmodule : ldm_link_delay_ptm_sync

`default_nettype wire

//--- rtl/ldm_ptm_pkg.sv
// Shared constants and carrier types for the link delay / PTM block.
// Assumes a 50 MHz core clock and a PTM local time counted in 100 ps ticks.
package ldm_ptm_pkg;

    // ==========================================================
    // Widths and register map
    // ==========================================================
    localparam int TW = 32;
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] ISOCH_OFS = 4'h4;
    localparam logic [3:0] STATUS_OFS = 4'h8;
    localparam logic [3:0] LINK_DELAY_OFS = 4'hC;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam logic [31:0] ISOCH_RESET = 32'h00000000;
    localparam int CTRL_GEN2_BIT = 0;
    localparam int CTRL_HOST_BIT = 1;
    localparam int STATUS_EN_BIT = 0;
    localparam int STATUS_VALID_BIT = 1;
    localparam int STATUS_REQ_LSB = 4;
    localparam int STATUS_RSP_LSB = 8;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_PS = 20000;
    localparam int TICK_PS = 100;
    localparam int TICKS_PER_CLK = CLK_PERIOD_PS / TICK_PS;
    localparam int GEN1_TP_UI = 200;
    localparam int GEN2_TP_UI = 165;
    localparam int GEN1_UI_PS = 200;
    localparam int GEN2_UI_PS = 100;
    localparam int GEN1_TP_TICKS = GEN1_TP_UI * GEN1_UI_PS / TICK_PS;
    localparam int GEN2_TP_TICKS = GEN2_TP_UI * GEN2_UI_PS / TICK_PS;
    localparam int BUS_INTERVAL_DELTAS = 7500;
    localparam logic [1:0] INIT_TIMEOUT_LIMIT = 2'h3;

    // ==========================================================
    // Link control word
    // ==========================================================
    localparam int LCW_DL_BIT = 10;
    localparam logic [4:0] CRC5_INIT = 5'h1F;
    localparam logic [4:0] CRC5_POLY = 5'h05;

    // ==========================================================
    // States and carriers
    // ==========================================================
    typedef enum logic [2:0] {
        REQ_INIT_REQUEST, REQ_INIT_RESPONSE, REQ_TS_REQUEST, REQ_TS_RESPONSE, REQ_DISABLED
    } req_state_e;

    typedef enum logic [1:0] {
        RSP_DISABLED, RSP_TS_REQUEST, RSP_TS_RESPONSE
    } rsp_state_e;

    typedef struct packed {
        logic delayed;
        logic [TW-1:0] resp_delay;
    } ts_rsp_in_s;

    typedef struct packed {
        logic [15:0] lcw;
        logic [TW-1:0] resp_delay;
    } ts_rsp_out_s;

    typedef struct packed {
        logic [13:0] bic;
        logic [12:0] delta;
        logic [6:0] corr;
    } itp_s;

endpackage : ldm_ptm_pkg

//--- verif/ldm_link_partner_model.sv
// Behavioural far-end port that answers timestamp requests.
// Assumes one-cycle request strobes on the core clock.
`timescale 1ns/10ps
`default_nettype none
module ldm_link_partner_model #(
    parameter int LAT = 8
) (
    input wire logic clk_i,
    input wire logic ts_req_tx_i,
    input wire logic mute_i,
    input wire logic dl_i,
    input wire logic [31:0] rd_i,
    output var logic rsp_rx_o = 1'b0,
    output var ldm_ptm_pkg::ts_rsp_in_s rsp_o = '0
);
    // ==========================================
    // Fixed-latency answer
    // ==========================================
    int cnt = 0;
    always @(posedge clk_i) begin
        if (ts_req_tx_i && !mute_i) begin
            cnt <= LAT;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
        rsp_rx_o <= (cnt == 1);
        // Idle payload toggles so stale data never looks fresh
        rsp_o <= (cnt == 1) ? {dl_i, rd_i} : ~rsp_o;
    end
endmodule : ldm_link_partner_model
`default_nettype wire

//--- verif/ldm_link_delay_ptm_sync_assertions.sv
// Port-level checks for the link delay / PTM block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module ldm_link_delay_ptm_sync_checker #(
    parameter int RSP_TIMEOUT_NS = 10000,
    parameter int RSP_DELAY_LIMIT_NS = 20000
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic bus_reset_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic set_feature_ldm_i,
    input wire logic clear_feature_ldm_i,
    input wire logic ts_rsp_rx_i,
    input wire ldm_ptm_pkg::ts_rsp_in_s ts_rsp_in_i,
    input wire logic ts_req_tx_o,
    input wire logic ldm_enabled_o,
    input wire logic ldm_valid_o,
    input wire logic resp_ldm_enabled_i,
    input wire logic ts_rsp_tx_o,
    input wire ldm_ptm_pkg::ts_rsp_out_s ts_rsp_out_o,
    input wire logic itp_tx_req_i,
    input wire logic itp_tx_stb_o,
    input wire ldm_ptm_pkg::itp_s itp_tx_data_o
);
    // ==========================================
    // Checks
    // ==========================================
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);
    localparam int DL_TICKS = RSP_TIMEOUT_NS * 10;
    localparam int LIMIT_TICKS = RSP_DELAY_LIMIT_NS * 10;
    sequence s_itp_sent;
        itp_tx_stb_o;
    endsequence
    sequence s_itp_clean;
        $past(itp_tx_req_i) && (itp_tx_data_o.corr == 7'h00);
    endsequence
    a_req_one_cycle: assert property (ts_req_tx_o |=> !ts_req_tx_o)
        else $error("request strobe longer than one cycle");
    a_valid_from_rsp: assert property ($rose(ldm_valid_o) |->
        $past(ts_rsp_rx_i) && !$past(ts_rsp_in_i.delayed))
        else $error("valid rose without a clean response");
    a_clear_disables: assert property (clear_feature_ldm_i && !bus_reset_i
        |-> ##[1:2] !ldm_enabled_o) else $error("clear feature did not disable");
    a_set_enables: assert property (set_feature_ldm_i && !clear_feature_ldm_i
        |-> ##[1:2] ldm_enabled_o) else $error("set feature did not enable");
    a_rsp_refused: assert property (!resp_ldm_enabled_i |=> !ts_rsp_tx_o)
        else $error("response sent while disabled");
    a_rsp_in_limit: assert property (ts_rsp_tx_o |->
        ts_rsp_out_o.resp_delay < LIMIT_TICKS) else $error("response delay over limit");
    a_dl_flag_match: assert property (ts_rsp_tx_o |->
        ts_rsp_out_o.lcw[15] == (ts_rsp_out_o.resp_delay > DL_TICKS))
        else $error("delayed flag wrong");
    a_itp_host_zero: assert property (s_itp_sent |-> s_itp_clean)
        else $error("host frame strobe without request or with correction");
    a_reg_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("read data outside read cycle");
endmodule : ldm_link_delay_ptm_sync_checker
bind ldm_link_delay_ptm_sync ldm_link_delay_ptm_sync_checker #(
    .RSP_TIMEOUT_NS(RSP_TIMEOUT_NS), .RSP_DELAY_LIMIT_NS(RSP_DELAY_LIMIT_NS)
) i_ldm_link_delay_ptm_sync_checker (
    .core_clk_i, .nrst_i, .bus_reset_i, .reg_rd_i, .reg_rdata_o, .set_feature_ldm_i,
    .clear_feature_ldm_i, .ts_rsp_rx_i, .ts_rsp_in_i, .ts_req_tx_o, .ldm_enabled_o,
    .ldm_valid_o, .resp_ldm_enabled_i, .ts_rsp_tx_o, .ts_rsp_out_o, .itp_tx_req_i,
    .itp_tx_stb_o, .itp_tx_data_o
);
`default_nettype wire

//--- verif/ldm_link_delay_ptm_sync_tb_top.sv
// Self-checking bench for requester, responder and PTM counters.
// Assumes the partner model answers each unmuted request after LAT cycles.
`timescale 1ns/10ps
`default_nettype none
module ldm_link_delay_ptm_sync_tb_top;
    // ==========================================
    // Signals and instances
    // ==========================================
    localparam int LAT = 8;
    logic core_clk_i = 1'b0, nrst_i = 1'b0, bus_reset_i = 1'b0, reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0, req_trigger_i = 1'b0, set_feature_ldm_i = 1'b0;
    logic clear_feature_ldm_i = 1'b0, resp_ldm_enabled_i = 1'b0, ts_req_rx_i = 1'b0;
    logic rsp_trigger_i = 1'b0, itp_rx_i = 1'b0, itp_tx_req_i = 1'b0, p_mute = 1'b0, p_dl = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0, p_rd = 32'h258, reg_rdata_o, link_delay_o, s;
    logic [10:0] lcw_base_i = 11'h2AB;
    logic ts_rsp_rx_i, ts_req_tx_o, ldm_enabled_o, ldm_valid_o, ts_rsp_tx_o, itp_tx_stb_o;
    logic [12:0] ptm_delta_o;
    logic [13:0] ptm_bic_o;
    ldm_ptm_pkg::ts_rsp_in_s ts_rsp_in_i;
    ldm_ptm_pkg::ts_rsp_out_s ts_rsp_out_o;
    ldm_ptm_pkg::itp_s itp_rx_data_i = '0, itp_tx_data_o;
    int failures = 0, tests_run = 0, cyc = 0, nreq = 0, nrsp = 0;
    // Short timeouts: 200 cycles to time out, 400 cycles response limit
    ldm_link_delay_ptm_sync #(.RSP_TIMEOUT_NS(4000), .RSP_DELAY_LIMIT_NS(8000))
    i_ldm_link_delay_ptm_sync (
        .core_clk_i, .nrst_i, .bus_reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .req_trigger_i, .set_feature_ldm_i, .clear_feature_ldm_i, .ts_rsp_rx_i,
        .ts_rsp_in_i, .ts_req_tx_o, .ldm_enabled_o, .ldm_valid_o, .link_delay_o,
        .resp_ldm_enabled_i, .ts_req_rx_i, .rsp_trigger_i, .lcw_base_i, .ts_rsp_tx_o,
        .ts_rsp_out_o, .itp_rx_i, .itp_rx_data_i, .itp_tx_req_i, .itp_tx_stb_o,
        .itp_tx_data_o, .ptm_delta_o, .ptm_bic_o);
    ldm_link_partner_model #(.LAT(LAT)) i_ldm_link_partner_model (.clk_i(core_clk_i),
        .ts_req_tx_i(ts_req_tx_o), .mute_i(p_mute), .dl_i(p_dl), .rd_i(p_rd),
        .rsp_rx_o(ts_rsp_rx_i), .rsp_o(ts_rsp_in_i));
    always #10 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cyc++;
        if (ts_req_tx_o === 1'b1) nreq++;
        if (ts_rsp_tx_o === 1'b1) nrsp++;
        if (cyc == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    // ==========================================
    // Tasks
    // ==========================================
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : tick
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        tick(1);
        reg_wr_i <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        tick(1);
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
        s = reg_rdata_o;
        tick(1);
    endtask : rd_reg
    task automatic trig();
        req_trigger_i <= 1'b1;
        tick(1);
        req_trigger_i <= 1'b0;
    endtask : trig
    task automatic exchange(input logic [31:0] exp);
        trig();
        tick(LAT + 4);
        check(link_delay_o, exp);
        rd_reg(ldm_ptm_pkg::LINK_DELAY_OFS);
        check(s, exp);
    endtask : exchange
    task automatic rsp_try(input int d);
        ts_req_rx_i <= 1'b1;
        tick(1);
        ts_req_rx_i <= 1'b0;
        tick(d - 1);
        rsp_trigger_i <= 1'b1;
        tick(1);
        rsp_trigger_i <= 1'b0;
        @(negedge core_clk_i);
    endtask : rsp_try
    task automatic report_and_stop();
        $display("checks run %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // ==========================================
    // Sequence
    // ==========================================
    initial begin
        int n, d;
        tick(4);
        nrst_i <= 1'b1;
        tick(1);
        rd_reg(ldm_ptm_pkg::CTRL_OFS);
        check(s, ldm_ptm_pkg::CTRL_RESET);
        rd_reg(4'h2);
        check(s, 32'h0);
        rd_reg(ldm_ptm_pkg::STATUS_OFS);
        check(s, 32'h1);
        exchange(32'h2BC);
        rd_reg(ldm_ptm_pkg::STATUS_OFS);
        check(s, 32'h23);
        wr_reg(ldm_ptm_pkg::CTRL_OFS, 32'h1);
        exchange(32'h1D1);
        p_dl <= 1'b1;
        trig();
        tick(LAT + 2);
        p_dl <= 1'b0;
        p_rd <= 32'hC8;
        @(negedge core_clk_i);
        @(negedge core_clk_i);
        check(32'(ts_req_tx_o), 32'h1);
        tick(LAT + 4);
        check(link_delay_o, 32'h299);
        p_mute <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            trig();
            tick(215);
            rd_reg(ldm_ptm_pkg::STATUS_OFS);
            check(32'(s[6:4]), (k >= 2) ? 32'h4 : 32'h0);
        end
        n = nreq;
        trig();
        tick(4);
        check(32'(nreq - n), 32'h0);
        set_feature_ldm_i <= 1'b1;
        tick(1);
        set_feature_ldm_i <= 1'b0;
        rd_reg(ldm_ptm_pkg::STATUS_OFS);
        check(32'({s[6:4], s[0]}), 32'h1);
        clear_feature_ldm_i <= 1'b1;
        tick(1);
        clear_feature_ldm_i <= 1'b0;
        rd_reg(ldm_ptm_pkg::STATUS_OFS);
        check(32'({s[6:4], s[0]}), 32'h8);
        n = nrsp;
        rsp_try(1);
        tick(2);
        check(32'(nrsp - n), 32'h0);
        resp_ldm_enabled_i <= 1'b1;
        tick(1);
        rd_reg(ldm_ptm_pkg::STATUS_OFS);
        check(32'(s[9:8]), 32'h1);
        for (int k = 0; k < 3; k++) begin
            d = (k == 0) ? 1 : (k == 1) ? 250 : 400;
            rsp_try(d);
            check(32'(ts_rsp_tx_o), 32'(d < 400));
            if (d < 400) check(ts_rsp_out_o.resp_delay, 32'(d * 200));
            if (d < 400) check(32'(ts_rsp_out_o.lcw[15:5]), {d * 200 > 40000, lcw_base_i[9:0]});
            tick(1);
        end
        wr_reg(ldm_ptm_pkg::ISOCH_OFS, 32'h10);
        itp_rx_data_i <= '{bic: 14'h5, delta: 13'h1D4C, corr: 7'h4};
        itp_rx_i <= 1'b1;
        tick(1);
        itp_rx_i <= 1'b0;
        @(negedge core_clk_i);
        check(32'(ptm_bic_o), 32'h0);
        tick(1);
        itp_rx_data_i.delta <= 13'h1CE8;
        itp_rx_i <= 1'b1;
        tick(1);
        itp_rx_i <= 1'b0;
        @(negedge core_clk_i);
        check(32'(ptm_delta_o), 32'h241);
        check(32'(ptm_bic_o), 32'h6);
        tick(1);
        wr_reg(ldm_ptm_pkg::CTRL_OFS, 32'h2);
        itp_tx_req_i <= 1'b1;
        tick(1);
        itp_tx_req_i <= 1'b0;
        @(negedge core_clk_i);
        check(32'({itp_tx_stb_o, itp_tx_data_o.corr}), 32'h80);
        check(32'({itp_tx_data_o.bic, itp_tx_data_o.delta}), 32'({14'h0006, 13'h0243}));
        tick(1);
        report_and_stop();
    end
endmodule : ldm_link_delay_ptm_sync_tb_top
`default_nettype wire
